// *** design/cid_consts.vh ***
`ifndef CID_CONSTS_VH
`define CID_CONSTS_VH

// ----------------------------------------------------------------------
// opcode bytes and patterns
// ----------------------------------------------------------------------
`define CID_OPC_SEG_LOAD     8'h8E
`define CID_OPC_SEG_STORE    8'h8C
`define CID_OPC_OUT_HI7      7'h73
`define CID_OPC_TBL_TRANS    8'hD7
`define CID_OPC_EA_LOAD      8'h8D
`define CID_OPC_FLAGS_TO_HI  8'h9F
`define CID_OPC_HI_TO_FLAGS  8'h9E
`define CID_OPC_ADJ_MUL      8'hD4
`define CID_OPC_ADJ_DIV      8'hD5
`define CID_ADJ_BASE         8'h0A
`define CID_OPC_BYTE_EXT     8'h98
`define CID_OPC_WORD_EXT     8'h99
`define CID_OPC_ADD_HI6      6'h00
`define CID_OPC_GRP3_HI7     7'h7B
`define CID_OPC_BR_EQ        8'h74
`define CID_OPC_RET_IMM      8'hC2
`define CID_OPC_PACK_ADD     8'h27
`define CID_OPC_PACK_SUB     8'h2F

// ----------------------------------------------------------------------
// secondary field of the arithmetic group
// ----------------------------------------------------------------------
`define CID_SUB_INVERT       3'h2
`define CID_SUB_SMUL         3'h5
`define CID_SUB_UDIV         3'h6

// ----------------------------------------------------------------------
// addressing byte fields
// ----------------------------------------------------------------------
`define CID_MOD_NODISP       2'h0
`define CID_MOD_DISP8        2'h1
`define CID_MOD_DISP16       2'h2
`define CID_MOD_REG          2'h3
`define CID_RM_DIRECT        3'h6
`define CID_RM_BX_SI         3'h0
`define CID_RM_BX_DI         3'h1
`define CID_RM_BP_SI         3'h2
`define CID_RM_BP_DI         3'h3
`define CID_RM_SI            3'h4
`define CID_RM_DI            3'h5
`define CID_RM_BP            3'h6
`define CID_FLD_MOD          7:6
`define CID_FLD_REG          5:3
`define CID_FLD_RM           2:0
`define CID_BIT_W            0
`define CID_BIT_D            1

// ----------------------------------------------------------------------
// operation codes presented to the datapath
// ----------------------------------------------------------------------
`define CID_OP_NONE          5'h00
`define CID_OP_SEG_LOAD      5'h01
`define CID_OP_SEG_STORE     5'h02
`define CID_OP_OUT_FIXED     5'h03
`define CID_OP_TBL_TRANS     5'h04
`define CID_OP_EA_LOAD       5'h05
`define CID_OP_FLAGS_TO_HI   5'h06
`define CID_OP_HI_TO_FLAGS   5'h07
`define CID_OP_ADJ_MUL       5'h08
`define CID_OP_ADJ_DIV       5'h09
`define CID_OP_BYTE_EXT      5'h0A
`define CID_OP_WORD_EXT      5'h0B
`define CID_OP_ADD_RM        5'h0C
`define CID_OP_SMUL          5'h0D
`define CID_OP_UDIV          5'h0E
`define CID_OP_INVERT        5'h0F
`define CID_OP_BR_EQ         5'h10
`define CID_OP_RET_ADD_SP    5'h11
`define CID_OP_PACK_ADD      5'h12
`define CID_OP_PACK_SUB      5'h13
`define CID_OP_GRP3          5'h1E
`define CID_OP_UNKNOWN       5'h1F

// ----------------------------------------------------------------------
// address base selects {bx, bp, si, di}
// ----------------------------------------------------------------------
`define CID_EA_BX            4'h8
`define CID_EA_BP            4'h4
`define CID_EA_SI            4'h2
`define CID_EA_DI            4'h1

`endif

// *** design/cid_opclass.v ***
`timescale 1ns/1ps
`include "cid_consts.vh"

// ----------------------------------------------------------------------
// first-byte classifier: operation, addressing byte, trailing bytes
// ----------------------------------------------------------------------
module cid_opclass
(
  input  wire [7:0] opcode_i,
  output reg  [4:0] op_class_o,
  output reg        has_modrm_o,
  output reg  [1:0] imm_cnt_o,
  output reg        imm_sext_o
);

  always @*
  begin
    op_class_o  = `CID_OP_UNKNOWN;
    has_modrm_o = 1'b0;
    imm_cnt_o   = 2'h0;
    imm_sext_o  = 1'b0;
    if (opcode_i == `CID_OPC_SEG_LOAD)
    begin
      op_class_o  = `CID_OP_SEG_LOAD;
      has_modrm_o = 1'b1;
    end
    else if (opcode_i == `CID_OPC_SEG_STORE)
    begin
      op_class_o  = `CID_OP_SEG_STORE;
      has_modrm_o = 1'b1;
    end
    else if (opcode_i[7:1] == `CID_OPC_OUT_HI7)
    begin
      op_class_o = `CID_OP_OUT_FIXED;
      imm_cnt_o  = 2'h1;
    end
    else if (opcode_i == `CID_OPC_TBL_TRANS)
      op_class_o = `CID_OP_TBL_TRANS;
    else if (opcode_i == `CID_OPC_EA_LOAD)
    begin
      op_class_o  = `CID_OP_EA_LOAD;
      has_modrm_o = 1'b1;
    end
    else if (opcode_i == `CID_OPC_FLAGS_TO_HI)
      op_class_o = `CID_OP_FLAGS_TO_HI;
    else if (opcode_i == `CID_OPC_HI_TO_FLAGS)
      op_class_o = `CID_OP_HI_TO_FLAGS;
    else if (opcode_i == `CID_OPC_ADJ_MUL)
    begin
      op_class_o = `CID_OP_ADJ_MUL;
      imm_cnt_o  = 2'h1;
    end
    else if (opcode_i == `CID_OPC_ADJ_DIV)
    begin
      op_class_o = `CID_OP_ADJ_DIV;
      imm_cnt_o  = 2'h1;
    end
    else if (opcode_i == `CID_OPC_BYTE_EXT)
      op_class_o = `CID_OP_BYTE_EXT;
    else if (opcode_i == `CID_OPC_WORD_EXT)
      op_class_o = `CID_OP_WORD_EXT;
    else if (opcode_i[7:2] == `CID_OPC_ADD_HI6)
    begin
      op_class_o  = `CID_OP_ADD_RM;
      has_modrm_o = 1'b1;
    end
    else if (opcode_i[7:1] == `CID_OPC_GRP3_HI7)
    begin
      op_class_o  = `CID_OP_GRP3;
      has_modrm_o = 1'b1;
    end
    else if (opcode_i == `CID_OPC_BR_EQ)
    begin
      op_class_o = `CID_OP_BR_EQ;
      imm_cnt_o  = 2'h1;
      imm_sext_o = 1'b1;
    end
    else if (opcode_i == `CID_OPC_RET_IMM)
    begin
      op_class_o = `CID_OP_RET_ADD_SP;
      imm_cnt_o  = 2'h2;
    end
    else if (opcode_i == `CID_OPC_PACK_ADD)
      op_class_o = `CID_OP_PACK_ADD;
    else if (opcode_i == `CID_OPC_PACK_SUB)
      op_class_o = `CID_OP_PACK_SUB;
  end

endmodule // cid_opclass

// *** design/cid_decoder.v ***
// How it works
// - mode 00 gives zero displacement and no displacement bytes, bar direct.
// - mode 00 with select 110 takes a 16-bit direct address, low first.
// - mode 01 reads one byte and sign-extends it to 16 bits.
// - mode 10 reads low then high displacement byte into 16 bits.
// - mode 11 makes the select field a register number.
// - displacement bytes follow the addressing byte, only when needed.
// - 8E with addressing byte loads a segment register from r/m.
// - 8C with addressing byte stores a segment register to r/m.
// - 1110011w outputs byte or word accumulator to a fixed port.
// - D7 replaces low accumulator byte through a translation table.
// - 8D places the effective address itself in the register.
// - 9F copies low flags to high accumulator; 9E copies them back.
// - D4 0A is the unpacked adjust after multiply.
// - D5 0A is the unpacked adjust before divide.
// - 98 extends byte to word; 99 extends word to doubleword.
// - 000000dw adds register and r/m, d picks destination, w width.
// - 1111011w with field 101 is a signed multiply.
// - 1111011w with field 110 is an unsigned divide.
// - 1111011w with field 010 inverts the r/m operand.
// - 74 with one displacement byte branches when equal.
// - C2 returns and adds a 16-bit immediate, low first, to the stack pointer.
// - 27 is packed adjust after add; 2F after subtract.
`timescale 1ns/1ps
`include "cid_consts.vh"

module cid_decoder
(
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [7:0]  byte_i,
  input  wire        byte_valid_i,
  output reg         byte_ready_o,
  output reg         op_valid_o,
  output reg  [4:0]  op_code_o,
  output reg         illegal_o,
  output reg         width_o,
  output reg         dir_o,
  output reg  [1:0]  mod_o,
  output reg  [2:0]  reg_o,
  output reg  [2:0]  rm_o,
  output reg         reg_operand_o,
  output reg         direct_addr_o,
  output reg  [3:0]  ea_use_o,
  output reg  [15:0] disp_o,
  output reg  [15:0] imm_o
);

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam [2:0] ST_OPC     = 3'h0;
  localparam [2:0] ST_MODRM   = 3'h1;
  localparam [2:0] ST_DISP_LO = 3'h2;
  localparam [2:0] ST_DISP_HI = 3'h3;
  localparam [2:0] ST_IMM_LO  = 3'h4;
  localparam [2:0] ST_IMM_HI  = 3'h5;

  reg  [2:0] state_r;
  reg  [4:0] op_fin_r;
  reg  [1:0] imm_cnt_r;
  reg        imm_sext_r;
  reg        bad_r;

  wire [4:0] cls;
  wire       cls_modrm;
  wire [1:0] cls_imm;
  wire       cls_sext;
  wire       take;

  assign take = byte_valid_i & byte_ready_o;

  // --------------------------------------------------------------------
  // first-byte classification
  // --------------------------------------------------------------------
  cid_opclass cid_opclass_inst
  (
    .opcode_i    (byte_i),
    .op_class_o  (cls),
    .has_modrm_o (cls_modrm),
    .imm_cnt_o   (cls_imm),
    .imm_sext_o  (cls_sext)
  );

  // --------------------------------------------------------------------
  // addressing byte decode
  // --------------------------------------------------------------------
  wire [1:0] b_mod = byte_i[`CID_FLD_MOD];
  wire [2:0] b_reg = byte_i[`CID_FLD_REG];
  wire [2:0] b_rm  = byte_i[`CID_FLD_RM];
  wire       b_direct;
  wire       need_disp;
  wire       need_imm;
  wire       adj_bad;
  reg  [1:0] disp_cnt;
  reg  [3:0] ea_sel;
  reg  [4:0] op_mod;
  reg        mod_bad;

  assign b_direct = (b_mod == `CID_MOD_NODISP) &&
                    (b_rm == `CID_RM_DIRECT);

  // the direct form borrows the no-displacement code yet carries a full
  // address, so it counts two trailing bytes like the long displacement
  always @*
  begin
    disp_cnt = 2'h0;
    if (b_mod == `CID_MOD_NODISP)
      disp_cnt = b_direct ? 2'h2 : 2'h0;
    else if (b_mod == `CID_MOD_DISP8)
      disp_cnt = 2'h1;
    else if (b_mod == `CID_MOD_DISP16)
      disp_cnt = 2'h2;
    else
      disp_cnt = 2'h0;
  end

  // trailing bytes are only fetched when the form asks for them
  assign need_disp = (disp_cnt != 2'h0);
  assign need_imm  = (imm_cnt_r != 2'h0);

  // the adjust forms are only defined with base ten; another second
  // byte is flagged rather than run with a base nobody asked for
  assign adj_bad = (op_fin_r == `CID_OP_ADJ_MUL ||
                    op_fin_r == `CID_OP_ADJ_DIV) &&
                   (byte_i != `CID_ADJ_BASE);

  always @*
  begin
    ea_sel = 4'h0;
    if (b_rm == `CID_RM_BX_SI)
      ea_sel = `CID_EA_BX | `CID_EA_SI;
    else if (b_rm == `CID_RM_BX_DI)
      ea_sel = `CID_EA_BX | `CID_EA_DI;
    else if (b_rm == `CID_RM_BP_SI)
      ea_sel = `CID_EA_BP | `CID_EA_SI;
    else if (b_rm == `CID_RM_BP_DI)
      ea_sel = `CID_EA_BP | `CID_EA_DI;
    else if (b_rm == `CID_RM_SI)
      ea_sel = `CID_EA_SI;
    else if (b_rm == `CID_RM_DI)
      ea_sel = `CID_EA_DI;
    else if (b_rm == `CID_RM_BP)
      ea_sel = `CID_EA_BP;
    else
      ea_sel = `CID_EA_BX;
    // register operands and the direct form use no base at all
    if (b_mod == `CID_MOD_REG || b_direct)
      ea_sel = 4'h0;
  end

  always @*
  begin
    op_mod  = op_fin_r;
    mod_bad = 1'b0;
    if (op_fin_r == `CID_OP_GRP3)
    begin
      if (b_reg == `CID_SUB_SMUL)
        op_mod = `CID_OP_SMUL;
      else if (b_reg == `CID_SUB_UDIV)
        op_mod = `CID_OP_UDIV;
      else if (b_reg == `CID_SUB_INVERT)
        op_mod = `CID_OP_INVERT;
      else
      begin
        op_mod  = `CID_OP_UNKNOWN;
        mod_bad = 1'b1;
      end
    end
    // segment moves only have four segment registers to name
    else if ((op_fin_r == `CID_OP_SEG_LOAD ||
              op_fin_r == `CID_OP_SEG_STORE) && b_reg[2])
      mod_bad = 1'b1;
    // an address is the only thing the effective-address load can take
    else if (op_fin_r == `CID_OP_EA_LOAD && b_mod == `CID_MOD_REG)
      mod_bad = 1'b1;
  end

  // --------------------------------------------------------------------
  // byte sequencer
  // --------------------------------------------------------------------
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r       <= ST_OPC;
      op_fin_r      <= `CID_OP_NONE;
      imm_cnt_r     <= 2'h0;
      imm_sext_r    <= 1'b0;
      bad_r         <= 1'b0;
      byte_ready_o  <= 1'b0;
      op_valid_o    <= 1'b0;
      op_code_o     <= `CID_OP_NONE;
      illegal_o     <= 1'b0;
      width_o       <= 1'b0;
      dir_o         <= 1'b0;
      mod_o         <= 2'h0;
      reg_o         <= 3'h0;
      rm_o          <= 3'h0;
      reg_operand_o <= 1'b0;
      direct_addr_o <= 1'b0;
      ea_use_o      <= 4'h0;
      disp_o        <= 16'h0000;
      imm_o         <= 16'h0000;
    end
    else
    begin
      // the stream is never stalled: every state takes one byte a cycle
      // op_code_o keeps naming the last finished instruction until the
      // next one completes; only the field outputs restart on an opcode
      byte_ready_o <= 1'b1;
      op_valid_o   <= 1'b0;
      if (take)
      begin
        case (state_r)
          ST_OPC:
          begin
            op_fin_r      <= cls;
            imm_cnt_r     <= cls_imm;
            imm_sext_r    <= cls_sext;
            bad_r         <= (cls == `CID_OP_UNKNOWN);
            width_o       <= byte_i[`CID_BIT_W];
            dir_o         <= byte_i[`CID_BIT_D];
            // a short form must not show fields left by the one before
            mod_o         <= 2'h0;
            reg_o         <= 3'h0;
            rm_o          <= 3'h0;
            reg_operand_o <= 1'b0;
            direct_addr_o <= 1'b0;
            ea_use_o      <= 4'h0;
            disp_o        <= 16'h0000;
            imm_o         <= 16'h0000;
            if (cls_modrm)
              state_r <= ST_MODRM;
            else if (cls_imm != 2'h0)
              state_r <= ST_IMM_LO;
            else
            begin
              op_code_o  <= cls;
              illegal_o  <= (cls == `CID_OP_UNKNOWN);
              op_valid_o <= 1'b1;
            end
          end
          ST_MODRM:
          begin
            mod_o         <= b_mod;
            reg_o         <= b_reg;
            rm_o          <= b_rm;
            reg_operand_o <= (b_mod == `CID_MOD_REG);
            direct_addr_o <= b_direct;
            ea_use_o      <= ea_sel;
            // the group's real operation is known only once reg arrives
            op_fin_r      <= op_mod;
            bad_r         <= bad_r | mod_bad;
            if (need_disp)
              state_r <= ST_DISP_LO;
            else if (need_imm)
              state_r <= ST_IMM_LO;
            else
            begin
              state_r    <= ST_OPC;
              op_code_o  <= op_mod;
              illegal_o  <= bad_r | mod_bad;
              op_valid_o <= 1'b1;
            end
          end
          ST_DISP_LO:
          begin
            // one byte sign-extended, or the low half of a long form
            if (mod_o == `CID_MOD_DISP8)
            begin
              disp_o <= {{8{byte_i[7]}}, byte_i};
              if (imm_cnt_r != 2'h0)
                state_r <= ST_IMM_LO;
              else
              begin
                state_r    <= ST_OPC;
                op_code_o  <= op_fin_r;
                illegal_o  <= bad_r;
                op_valid_o <= 1'b1;
              end
            end
            else
            begin
              disp_o[7:0] <= byte_i;
              state_r     <= ST_DISP_HI;
            end
          end
          ST_DISP_HI:
          begin
            disp_o[15:8] <= byte_i;
            if (imm_cnt_r != 2'h0)
              state_r <= ST_IMM_LO;
            else
            begin
              state_r    <= ST_OPC;
              op_code_o  <= op_fin_r;
              illegal_o  <= bad_r;
              op_valid_o <= 1'b1;
            end
          end
          ST_IMM_LO:
          begin
            if (imm_cnt_r == 2'h1)
            begin
              // branch offsets are signed, port numbers are not
              if (imm_sext_r)
                imm_o <= {{8{byte_i[7]}}, byte_i};
              else
                imm_o <= {8'h00, byte_i};
              state_r    <= ST_OPC;
              op_code_o  <= op_fin_r;
              op_valid_o <= 1'b1;
              illegal_o  <= bad_r | adj_bad;
            end
            else
            begin
              imm_o[7:0] <= byte_i;
              state_r    <= ST_IMM_HI;
            end
          end
          ST_IMM_HI:
          begin
            imm_o[15:8] <= byte_i;
            state_r     <= ST_OPC;
            op_code_o   <= op_fin_r;
            illegal_o   <= bad_r;
            op_valid_o  <= 1'b1;
          end
          // an unused state code can only come from an upset; drop the
          // partial instruction rather than guess where it stood
          default:
          begin
            state_r   <= ST_OPC;
            op_fin_r  <= `CID_OP_NONE;
            imm_cnt_r <= 2'h0;
            bad_r     <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // cid_decoder

// *** bench/cid_decoder_monitor.sv ***
`timescale 1ns/1ps
`include "cid_consts.vh"

module cid_decoder_monitor
(
  input wire        ref_clk_i,
  input wire        rst_i,
  input wire [7:0]  byte_i,
  input wire        byte_valid_i,
  input wire        byte_ready_o,
  input wire        op_valid_o,
  input wire [4:0]  op_code_o,
  input wire        illegal_o,
  input wire        width_o,
  input wire        dir_o,
  input wire [1:0]  mod_o,
  input wire [2:0]  reg_o,
  input wire [2:0]  rm_o,
  input wire        reg_operand_o,
  input wire        direct_addr_o,
  input wire [3:0]  ea_use_o,
  input wire [15:0] disp_o,
  input wire [15:0] imm_o
);
  // base selects for rm 7..0, one nibble each
  wire [31:0] base_tab = 32'h8412569A;
  wire [3:0]  base_sel = base_tab[rm_o*4 +: 4];
  wire        modrm_op = op_code_o inside {`CID_OP_SEG_LOAD,
    `CID_OP_SEG_STORE, `CID_OP_EA_LOAD, `CID_OP_ADD_RM, `CID_OP_SMUL,
    `CID_OP_UDIV, `CID_OP_INVERT};
  wire        vld = op_valid_o && !illegal_o;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_nodisp_zero:
  assert property (vld && mod_o == 2'h0 && !direct_addr_o |->
    disp_o == 16'h0000) else $error("displacement not zero in mode 0");
  chk_direct_flag:
  assert property (vld |-> direct_addr_o == (modrm_op && mod_o == 2'h0 &&
    rm_o == 3'h6)) else $error("direct address flag wrong");
  chk_disp8_sext:
  assert property (vld && mod_o == 2'h1 |-> disp_o[15:8] == {8{disp_o[7]}})
    else $error("short displacement not sign extended");
  chk_reg_mode:
  assert property (vld |-> reg_operand_o == (mod_o == 2'h3))
    else $error("register operand flag wrong");
  chk_reg_no_base:
  assert property (vld && mod_o == 2'h3 |->
    ea_use_o == 4'h0 && disp_o == 16'h0000)
    else $error("register mode carries memory base");
  chk_rm_base:
  assert property (vld && modrm_op && mod_o != 2'h3 && !direct_addr_o |->
    ea_use_o == base_sel) else $error("address base select wrong");
  chk_pulse_take:
  assert property (op_valid_o |-> $past(byte_valid_i && byte_ready_o))
    else $error("decode pulse without a byte taken");
  chk_adjust_base:
  assert property (op_valid_o && op_code_o inside {`CID_OP_ADJ_MUL,
    `CID_OP_ADJ_DIV} |-> illegal_o == (imm_o != 16'h000A))
    else $error("adjust second byte check wrong");
  chk_branch_sext:
  assert property (vld && op_code_o == `CID_OP_BR_EQ |->
    imm_o[15:8] == {8{imm_o[7]}}) else $error("branch offset not extended");
  chk_port_zext:
  assert property (vld && op_code_o == `CID_OP_OUT_FIXED |->
    imm_o[15:8] == 8'h00) else $error("port number not zero extended");
endmodule // cid_decoder_monitor

// *** bench/cid_fetch_model.sv ***
`timescale 1ns/1ps

module cid_fetch_model
(
  input  wire        ref_clk_i,
  input  wire        byte_ready_i,
  output logic [7:0] byte_o,
  output logic       byte_valid_o
);
  logic [7:0] fifo_q [$];
  logic       slow;
  logic       taken;
  initial
  begin
    byte_o = 8'hA5;
    byte_valid_o = 1'b0;
    slow = 1'b0;
  end
  // slow mode drops valid for a cycle after every byte taken
  always @(posedge ref_clk_i)
  begin
    taken = byte_valid_o && byte_ready_i;
    #1;
    if (taken)
      void'(fifo_q.pop_front());
    if (fifo_q.size() > 0 && !(taken && slow))
    begin
      byte_valid_o = 1'b1;
      byte_o = fifo_q[0];
    end
    else
    begin
      // an idle bus must not look like a held byte
      byte_valid_o = 1'b0;
      byte_o = ~byte_o;
    end
  end
endmodule // cid_fetch_model

// *** bench/cid_decoder_tb.sv ***
`timescale 1ns/1ps
`include "cid_consts.vh"

module cid_decoder_tb;
  logic        ref_clk_i;
  logic        rst_i;
  logic [7:0]  byte_i;
  logic        byte_valid_i;
  logic        byte_ready_o;
  logic        op_valid_o;
  logic [4:0]  op_code_o;
  logic        illegal_o;
  logic        width_o;
  logic        dir_o;
  logic [1:0]  mod_o;
  logic [2:0]  reg_o;
  logic [2:0]  rm_o;
  logic        reg_operand_o;
  logic        direct_addr_o;
  logic [3:0]  ea_use_o;
  logic [15:0] disp_o;
  logic [15:0] imm_o;
  int          n_mismatch;
  int          total_checks;

  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  cid_decoder cid_decoder_inst (.ref_clk_i, .rst_i, .byte_i, .byte_valid_i,
    .byte_ready_o, .op_valid_o, .op_code_o, .illegal_o, .width_o, .dir_o,
    .mod_o, .reg_o, .rm_o, .reg_operand_o, .direct_addr_o, .ea_use_o,
    .disp_o, .imm_o);
  cid_fetch_model cid_fetch_model_inst (.ref_clk_i(ref_clk_i),
    .byte_ready_i(byte_ready_o), .byte_o(byte_i), .byte_valid_o(byte_valid_i));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic feed(input logic [7:0] b);
    cid_fetch_model_inst.fifo_q.push_back(b);
  endtask

  // wait for the next decode pulse; a flagged error hides the op code
  task automatic next_op(input logic [4:0] op, input logic bad);
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(negedge ref_clk_i);
      if (op_valid_o === 1'b1)
        break;
    end
    if (i == 40)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    if (!bad)
      chk({11'h000, op_code_o}, {11'h000, op});
    chk({15'h0000, illegal_o}, {15'h0000, bad});
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_modes;
    cid_fetch_model_inst.slow = 1'b1;
    feed(8'h8E); feed(8'h1F); feed(8'h00); feed(8'h06); feed(8'h34);
    feed(8'h12); feed(8'h8C); feed(8'h46); feed(8'hFC); feed(8'h8D);
    feed(8'h80); feed(8'h78); feed(8'h56); feed(8'h03); feed(8'hC3);
    next_op(`CID_OP_SEG_LOAD, 1'b0);
    chk(disp_o, 16'h0000);
    chk({12'h000, ea_use_o}, 16'h0008);
    chk({13'h0000, reg_o}, 16'h0003);
    next_op(`CID_OP_ADD_RM, 1'b0);
    chk({15'h0000, direct_addr_o}, 16'h0001);
    chk(disp_o, 16'h1234);
    next_op(`CID_OP_SEG_STORE, 1'b0);
    chk(disp_o, 16'hFFFC);
    chk({14'h0000, mod_o}, 16'h0001);
    chk({12'h000, ea_use_o}, 16'h0004);
    next_op(`CID_OP_EA_LOAD, 1'b0);
    chk(disp_o, 16'h5678);
    chk({12'h000, ea_use_o}, 16'h000A);
    next_op(`CID_OP_ADD_RM, 1'b0);
    chk({15'h0000, reg_operand_o}, 16'h0001);
    chk({13'h0000, rm_o}, 16'h0003);
    chk({14'h0000, dir_o, width_o}, 16'h0003);
    cid_fetch_model_inst.slow = 1'b0;
  endtask

  task automatic t_bases;
    logic [31:0] tab;
    int r;
    tab = 32'h8412569A;
    for (r = 0; r < 8; r++)
    begin
      feed(8'h8D);
      feed({2'h1, 3'h0, r[2:0]});
      feed(8'h80);
    end
    for (r = 0; r < 8; r++)
    begin
      next_op(`CID_OP_EA_LOAD, 1'b0);
      chk({12'h000, ea_use_o}, {12'h000, tab[r*4 +: 4]});
      chk(disp_o, 16'hFF80);
    end
  endtask

  task automatic t_single;
    logic [7:0] opc [7];
    logic [4:0] exp_op [7];
    int k;
    opc = '{8'hD7, 8'h9F, 8'h9E, 8'h98, 8'h99, 8'h27, 8'h2F};
    exp_op = '{`CID_OP_TBL_TRANS, `CID_OP_FLAGS_TO_HI, `CID_OP_HI_TO_FLAGS,
      `CID_OP_BYTE_EXT, `CID_OP_WORD_EXT, `CID_OP_PACK_ADD, `CID_OP_PACK_SUB};
    for (k = 0; k < 7; k++)
      feed(opc[k]);
    for (k = 0; k < 7; k++)
      next_op(exp_op[k], 1'b0);
  endtask

  task automatic t_out_adjust;
    feed(8'hE6); feed(8'h44); feed(8'hE7); feed(8'h80);
    feed(8'hD4); feed(8'h0A); feed(8'hD5); feed(8'h0A);
    feed(8'hD4); feed(8'h0B);
    next_op(`CID_OP_OUT_FIXED, 1'b0);
    chk({15'h0000, width_o}, 16'h0000);
    chk(imm_o, 16'h0044);
    next_op(`CID_OP_OUT_FIXED, 1'b0);
    chk({15'h0000, width_o}, 16'h0001);
    chk(imm_o, 16'h0080);
    next_op(`CID_OP_ADJ_MUL, 1'b0);
    next_op(`CID_OP_ADJ_DIV, 1'b0);
    next_op(`CID_OP_ADJ_MUL, 1'b1);
  endtask

  task automatic t_group_branch;
    feed(8'hF7); feed(8'hE8); feed(8'hF6); feed(8'hF1); feed(8'hF7);
    feed(8'h16); feed(8'h34); feed(8'h12); feed(8'hF7); feed(8'hE0);
    feed(8'h74); feed(8'hF0); feed(8'hC2); feed(8'h34); feed(8'h12);
    feed(8'h27); feed(8'h8E); feed(8'h20);
    next_op(`CID_OP_SMUL, 1'b0);
    chk({15'h0000, width_o}, 16'h0001);
    next_op(`CID_OP_UDIV, 1'b0);
    chk({15'h0000, width_o}, 16'h0000);
    next_op(`CID_OP_INVERT, 1'b0);
    chk(disp_o, 16'h1234);
    next_op(`CID_OP_INVERT, 1'b1);
    next_op(`CID_OP_BR_EQ, 1'b0);
    chk(imm_o, 16'hFFF0);
    next_op(`CID_OP_RET_ADD_SP, 1'b0);
    chk(imm_o, 16'h1234);
    next_op(`CID_OP_PACK_ADD, 1'b0);
    next_op(`CID_OP_SEG_LOAD, 1'b1);
  endtask

  // a half-fetched instruction must not survive a reset
  task automatic t_reset;
    feed(8'h8D);
    repeat (3) @(posedge ref_clk_i);
    #1 rst_i = 1'b1;
    @(negedge ref_clk_i);
    chk({14'h0000, byte_ready_o, op_valid_o}, 16'h0000);
    @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    feed(8'h27);
    next_op(`CID_OP_PACK_ADD, 1'b0);
  endtask

  initial
  begin
    rst_i = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    repeat (10) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    t_modes();
    t_bases();
    t_single();
    t_out_adjust();
    t_group_branch();
    t_reset();
    tally_and_finish();
  end
endmodule // cid_decoder_tb

bind cid_decoder cid_decoder_monitor cid_decoder_monitor_inst (.ref_clk_i,
  .rst_i, .byte_i, .byte_valid_i, .byte_ready_o, .op_valid_o, .op_code_o,
  .illegal_o, .width_o, .dir_o, .mod_o, .reg_o, .rm_o, .reg_operand_o,
  .direct_addr_o, .ea_use_o, .disp_o, .imm_o);
